// *** rtl/lcd_mux4_segment_driver.sv ***
// Multiplexed-by-four segment display driver: serial input section and drive section
`timescale 1ns/1ps
module lcd_mux4_segment_driver
#(
  parameter int SEG_COUNT = lcd_drv_pkg::SEG_COUNT_DEF,
  parameter int PHASE_DIV = lcd_drv_pkg::PHASE_DIV_DEF,
  parameter bit IIC_VARIANT = 1'b0,
  parameter bit FIRST_BITS_PHASE1 = 1'b1
)
(
  // Timebase and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial link
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic display_latch_strobe,
  input wire logic [2:0] chip_select_straps,
  // Display planes
  output logic [lcd_drv_pkg::PHASES-1:0] common_plane_outputs,
  output logic common_plane_boost,
  output logic [SEG_COUNT/lcd_drv_pkg::PHASES-1:0] segment_plane_outputs
);
  import lcd_drv_pkg::*;
  localparam int CW = $clog2(SEG_COUNT);
  localparam logic [CW-1:0] SEG_LAST = CW'(SEG_COUNT - 1);

  // Link domain pin samplers and reset synchroniser
  logic [1:0] lrst_sync_reg;
  logic [1:0] strobe_l_sync_reg;
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_sync_reg;
  logic rise_bit_reg;
  logic lnk_rst_n;

  // Link domain receiver state, updated on the falling link edge
  rx_state_e rx_state_reg, rx_state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [CW-1:0] seg_cnt_reg, seg_cnt_next;
  logic [7:0] addr_reg, addr_next;
  logic [SEG_COUNT-1:0] sreg_reg, sreg_next;
  logic [SEG_COUNT-1:0] hold_reg, hold_next;
  logic tgl_reg, tgl_next;
  logic oe_reg, oe_next;
  logic rd_reg, rd_next;
  logic start_ev, stop_ev, bit_ev, addr_hit;
  logic [7:0] addr_full;

  // Timebase domain crossing state
  logic [1:0] tgl_sync_reg;
  logic [1:0] strobe_c_sync_reg;
  logic tgl_seen_reg, tgl_seen_next;
  logic strobe_prev_reg, strobe_prev_next;
  logic [SEG_COUNT-1:0] pending_reg, pending_next;
  logic auto_ev, ext_ev;

  // Sample the data bit at the rising edge; straps and strobe are pins, so two flops
  always_ff @(posedge serial_shift_clock)
  begin
    lrst_sync_reg <= {lrst_sync_reg[0], reset_n};
    strobe_l_sync_reg <= {strobe_l_sync_reg[0], display_latch_strobe};
    strap_meta_reg <= chip_select_straps;
    strap_sync_reg <= strap_meta_reg;
    rise_bit_reg <= serial_data_in;
  end

  assign lnk_rst_n = lrst_sync_reg[1];

  // Receiver: a data change while the clock is high is a start or a stop
  always_comb
  begin
    start_ev = rise_bit_reg & ~serial_data_in;
    stop_ev = ~rise_bit_reg & serial_data_in;
    bit_ev = ~start_ev & ~stop_ev;
    addr_full = {addr_reg[6:0], rise_bit_reg};
    if (IIC_VARIANT)
      addr_hit = strap_sync_reg == STRAP_NORMAL && addr_full[7:1] == DEV_ADDR[7:1];
    else
      addr_hit = strap_sync_reg == STRAP_NORMAL && addr_full == DEV_ADDR;
    rx_state_next = rx_state_reg;
    bit_cnt_next = bit_cnt_reg;
    seg_cnt_next = seg_cnt_reg;
    addr_next = addr_reg;
    sreg_next = sreg_reg;
    hold_next = hold_reg;
    tgl_next = tgl_reg;
    oe_next = oe_reg;
    rd_next = rd_reg;
    if (start_ev)
    begin
      rx_state_next = RX_ADDR;
      bit_cnt_next = '0;
      oe_next = 1'b0;
    end
    else if (stop_ev)
    begin
      rx_state_next = RX_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      case (rx_state_reg)
        RX_IDLE:
          rx_state_next = RX_IDLE;
        RX_ADDR:
        begin
          addr_next = addr_full;
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == LAST_BIT)
          begin
            seg_cnt_next = '0;
            rd_next = IIC_VARIANT & addr_full[0];
            oe_next = IIC_VARIANT & addr_hit;
            bit_cnt_next = IIC_VARIANT ? ACK_SLOT : 4'h0;
            rx_state_next = addr_hit ? RX_DATA : RX_IDLE;
          end
        end
        RX_DATA:
        begin
          if (IIC_VARIANT && bit_cnt_reg == ACK_SLOT)
          begin
            // End of the ninth clock: release, or put out the first read bit
            bit_cnt_next = 4'h0;
            oe_next = rd_reg & ~sreg_reg[SEG_COUNT-1];
            if (rd_reg)
              sreg_next = {sreg_reg[SEG_COUNT-2:0], sreg_reg[SEG_COUNT-1]};
          end
          else if (rd_reg)
          begin
            // Rotating keeps the stored image intact after a full read
            bit_cnt_next = bit_cnt_reg + 4'h1;
            oe_next = (bit_cnt_reg != LAST_BIT) & ~sreg_reg[SEG_COUNT-1];
            if (bit_cnt_reg != LAST_BIT)
              sreg_next = {sreg_reg[SEG_COUNT-2:0], sreg_reg[SEG_COUNT-1]};
          end
          else
          begin
            sreg_next = {sreg_reg[SEG_COUNT-2:0], rise_bit_reg};
            seg_cnt_next = (seg_cnt_reg == SEG_LAST) ? '0 : seg_cnt_reg + CW'(1);
            if (IIC_VARIANT)
              bit_cnt_next = bit_cnt_reg + 4'h1;
            oe_next = IIC_VARIANT && bit_cnt_reg == LAST_BIT;
            if (seg_cnt_reg == SEG_LAST)
            begin
              if (strobe_l_sync_reg[1])
              begin
                hold_next = sreg_next;
                tgl_next = ~tgl_reg;
              end
              // Serial variant ignores the clock after a full block
              if (!IIC_VARIANT)
                rx_state_next = RX_SKIP;
            end
          end
        end
        RX_SKIP:
          rx_state_next = RX_DATA;
        default:
          rx_state_next = RX_IDLE;
      endcase
    end
  end

  // Output changes happen while the link clock is low, as the master expects
  always_ff @(negedge serial_shift_clock)
  begin
    if (!lnk_rst_n)
    begin
      rx_state_reg <= RX_IDLE;
      bit_cnt_reg <= '0;
      seg_cnt_reg <= '0;
      addr_reg <= '0;
      sreg_reg <= '0;
      hold_reg <= '0;
      tgl_reg <= 1'b0;
      oe_reg <= 1'b0;
      rd_reg <= 1'b0;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      bit_cnt_reg <= bit_cnt_next;
      seg_cnt_reg <= seg_cnt_next;
      addr_reg <= addr_next;
      sreg_reg <= sreg_next;
      hold_reg <= hold_next;
      tgl_reg <= tgl_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
    end
  end

  // Open-drain data line: only ever pulled low
  assign serial_data_out = 1'b0;
  assign serial_data_oe = oe_reg;

  // Toggle and strobe synchronisers into the timebase domain
  always_ff @(posedge core_clk)
  begin
    tgl_sync_reg <= {tgl_sync_reg[0], tgl_reg};
    strobe_c_sync_reg <= {strobe_c_sync_reg[0], display_latch_strobe};
  end

  // Latch update; the strobe copy relies on the link clock sitting idle high
  always_comb
  begin
    auto_ev = tgl_sync_reg[1] ^ tgl_seen_reg;
    ext_ev = strobe_c_sync_reg[1] & ~strobe_prev_reg;
    tgl_seen_next = tgl_sync_reg[1];
    strobe_prev_next = strobe_c_sync_reg[1];
    pending_next = pending_reg;
    if (ext_ev)
      pending_next = sreg_reg;
    else if (auto_ev)
      pending_next = hold_reg;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      tgl_seen_reg <= 1'b0;
      strobe_prev_reg <= STROBE_PREV_RESET;
      pending_reg <= '0;
    end
    else
    begin
      tgl_seen_reg <= tgl_seen_next;
      strobe_prev_reg <= strobe_prev_next;
      pending_reg <= pending_next;
    end
  end

  // Drive section runs on the timebase alone
  lcd_plane_sequencer #(
    .SEG_COUNT(SEG_COUNT),
    .PHASE_DIV(PHASE_DIV),
    .FIRST_BITS_PHASE1(FIRST_BITS_PHASE1)
  ) u_planes (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .latched_data(pending_reg),
    .common_plane_outputs(common_plane_outputs),
    .common_plane_boost(common_plane_boost),
    .segment_plane_outputs(segment_plane_outputs)
  );

  // Checks on the input section
  property p_shift_in;
    @(negedge serial_shift_clock) disable iff (!lnk_rst_n)
      rx_state_reg == RX_DATA && !rd_reg && bit_ev && !(IIC_VARIANT && bit_cnt_reg == ACK_SLOT)
      |=> sreg_reg[0] == $past(rise_bit_reg) && sreg_reg[SEG_COUNT-1:1] == $past(sreg_reg[SEG_COUNT-2:0]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("data bit not shifted in");
  property p_skip;
    @(negedge serial_shift_clock) disable iff (!lnk_rst_n)
      rx_state_reg == RX_SKIP && bit_ev |=> rx_state_reg == RX_DATA && $stable(sreg_reg);
  endproperty
  a_skip: assert property (p_skip) else $error("ignored clock changed the register");
  property p_auto_latch;
    @(negedge serial_shift_clock) disable iff (!lnk_rst_n)
      rx_state_reg == RX_DATA && !rd_reg && bit_ev && seg_cnt_reg == SEG_LAST && strobe_l_sync_reg[1]
      && !(IIC_VARIANT && bit_cnt_reg == ACK_SLOT) |=> $changed(tgl_reg) && hold_reg == sreg_reg;
  endproperty
  a_auto_latch: assert property (p_auto_latch) else $error("block end did not latch");
  property p_ack;
    @(negedge serial_shift_clock) disable iff (!lnk_rst_n)
      IIC_VARIANT && rx_state_reg == RX_DATA && !rd_reg && bit_cnt_reg == LAST_BIT && bit_ev
      |=> oe_reg ##1 (!oe_reg || rx_state_reg != RX_DATA || !bit_ev);
  endproperty
  a_ack: assert property (p_ack) else $error("byte not acknowledged");
  property p_read_gap;
    @(negedge serial_shift_clock) disable iff (!lnk_rst_n)
      rx_state_reg == RX_DATA && rd_reg && bit_cnt_reg == LAST_BIT && bit_ev |=> !oe_reg;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("line not released after read byte");
  property p_miss;
    @(negedge serial_shift_clock) disable iff (!lnk_rst_n)
      rx_state_reg == RX_ADDR && bit_cnt_reg == LAST_BIT && bit_ev && !addr_hit
      |=> rx_state_reg == RX_IDLE && !oe_reg;
  endproperty
  a_miss: assert property (p_miss) else $error("answered a foreign address");
  property p_auto_copy;
    @(posedge core_clk) disable iff (!reset_n) auto_ev && !ext_ev |=> pending_reg == $past(hold_reg);
  endproperty
  a_auto_copy: assert property (p_auto_copy) else $error("latched block not taken over");
  property p_ext_copy;
    @(posedge core_clk) disable iff (!reset_n) ext_ev |=> pending_reg == $past(sreg_reg);
  endproperty
  a_ext_copy: assert property (p_ext_copy) else $error("strobe did not latch");
endmodule : lcd_mux4_segment_driver

// *** rtl/lcd_drv_pkg.sv ***
// Shared constants and types for the multiplexed segment display driver
package lcd_drv_pkg;
  // Display geometry
  localparam int SEG_COUNT_DEF = 128;
  localparam int PHASES = 4;
  localparam int PHASE_W = 2;
  localparam int PHASE_DIV_DEF = 256;
  // Link addressing
  localparam logic [7:0] DEV_ADDR = 8'h7e;
  localparam logic [2:0] STRAP_NORMAL = 3'h7;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // Backplane high-current window, in timebase periods
  localparam int BOOST_OSC_PERIODS = 4;
  localparam int BOOST_W = 3;
  localparam logic [BOOST_W-1:0] BOOST_CYCLES = BOOST_W'(BOOST_OSC_PERIODS);
  // Reset levels
  localparam logic STROBE_PREV_RESET = 1'b1;
  // Receiver states, Gray along idle, address, data, skip
  typedef enum logic [1:0]
  {
    RX_IDLE = 2'b00,
    RX_ADDR = 2'b01,
    RX_DATA = 2'b11,
    RX_SKIP = 2'b10
  } rx_state_e;
endpackage : lcd_drv_pkg

// *** rtl/lcd_plane_sequencer.sv ***
// Backplane sequencer and frontplane driver running from the timebase clock
`timescale 1ns/1ps
module lcd_plane_sequencer
#(
  parameter int SEG_COUNT = lcd_drv_pkg::SEG_COUNT_DEF,
  parameter int PHASE_DIV = lcd_drv_pkg::PHASE_DIV_DEF,
  parameter bit FIRST_BITS_PHASE1 = 1'b1
)
(
  // Timebase and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Display latch contents
  input wire logic [SEG_COUNT-1:0] latched_data,
  // Plane drivers
  output logic [lcd_drv_pkg::PHASES-1:0] common_plane_outputs,
  output logic common_plane_boost,
  output logic [SEG_COUNT/lcd_drv_pkg::PHASES-1:0] segment_plane_outputs
);
  import lcd_drv_pkg::*;
  localparam int FP = SEG_COUNT / PHASES;
  localparam int DW = $clog2(PHASE_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(PHASE_DIV - 1);
  typedef logic [PHASE_W-1:0] phase_t;

  // One backplane per phase
  function automatic logic [PHASES-1:0] plane_select(input phase_t p);
    plane_select = PHASES'(1) << p;
  endfunction : plane_select

  // Picks the block of bits for a phase; a one turns the driver on
  function automatic logic [FP-1:0] plane_group(input logic [SEG_COUNT-1:0] d, input phase_t p);
    int base;
    base = (FIRST_BITS_PHASE1 ? int'(p) : PHASES - 1 - int'(p)) * FP;
    for (int j = 0; j < FP; j++)
      plane_group[j] = d[SEG_COUNT - 1 - base - j];
  endfunction : plane_group

  logic [DW-1:0] div_reg, div_next;
  phase_t phase_reg, phase_next;
  logic [PHASES-1:0] bp_reg, bp_next;
  logic [FP-1:0] fp_reg, fp_next;
  logic [BOOST_W-1:0] boost_cnt_reg, boost_cnt_next;
  logic boost_reg, boost_next;
  logic wrap;

  // Phase timing is a plain division of the timebase, so the frame never stops
  always_comb
  begin
    wrap = div_reg == DIV_LAST;
    div_next = wrap ? '0 : div_reg + DW'(1);
    phase_next = wrap ? phase_reg + phase_t'(1) : phase_reg;
    bp_next = wrap ? plane_select(phase_next) : bp_reg;
    // New block only at a phase start, so a latch update never tears a phase
    fp_next = wrap ? plane_group(latched_data, phase_next) : fp_reg;
    if (wrap)
      boost_cnt_next = BOOST_CYCLES;
    else if (boost_cnt_reg != '0)
      boost_cnt_next = boost_cnt_reg - BOOST_W'(1);
    else
      boost_cnt_next = '0;
    boost_next = boost_cnt_next != '0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      div_reg <= '0;
      phase_reg <= '0;
      bp_reg <= plane_select('0);
      fp_reg <= '0;
      boost_cnt_reg <= '0;
      boost_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      phase_reg <= phase_next;
      bp_reg <= bp_next;
      fp_reg <= fp_next;
      boost_cnt_reg <= boost_cnt_next;
      boost_reg <= boost_next;
    end
  end

  assign common_plane_outputs = bp_reg;
  assign segment_plane_outputs = fp_reg;
  assign common_plane_boost = boost_reg;

  // Checks on the drive sequence
  property p_bp_onehot;
    @(posedge core_clk) disable iff (!reset_n) $onehot(bp_reg);
  endproperty
  a_bp_onehot: assert property (p_bp_onehot) else $error("backplane not one-hot");
  property p_bp_step;
    @(posedge core_clk) disable iff (!reset_n)
      $changed(bp_reg) |-> bp_reg == plane_select(phase_reg) && phase_reg == phase_t'($past(phase_reg) + 1);
  endproperty
  a_bp_step: assert property (p_bp_step) else $error("backplane skipped a phase");
  property p_boost;
    @(posedge core_clk) disable iff (!reset_n) $changed(bp_reg) |-> boost_reg [*4] ##1 !boost_reg;
  endproperty
  a_boost: assert property (p_boost) else $error("high-current window not four periods");
  property p_fp_load;
    @(posedge core_clk) disable iff (!reset_n)
      $changed(bp_reg) |-> fp_reg == plane_group($past(latched_data), phase_reg);
  endproperty
  a_fp_load: assert property (p_fp_load) else $error("frontplane block wrong at phase start");
  property p_fp_hold;
    @(posedge core_clk) disable iff (!reset_n) !$changed(bp_reg) |-> $stable(fp_reg);
  endproperty
  a_fp_hold: assert property (p_fp_hold) else $error("frontplane changed inside a phase");
  property p_div;
    @(posedge core_clk) disable iff (!reset_n) $changed(bp_reg) |-> div_reg == '0;
  endproperty
  a_div: assert property (p_div) else $error("phase change off the divider wrap");
endmodule : lcd_plane_sequencer

// *** testbench/serial_host_model.sv ***
// Host-side serial source: drives the link clock, the data wire and the latch strobe
`timescale 1ns/1ps
module serial_host_model
(
  // Link lines
  output logic serial_shift_clock,
  output logic host_data,
  output logic display_latch_strobe,
  // Resolved level of the data wire
  input wire logic data_wire
);
  localparam realtime QTR = 31.25;
  // Link idles with clock and data high and the strobe high
  initial
  begin
    serial_shift_clock = 1'b1;
    host_data = 1'b1;
    display_latch_strobe = 1'b1;
  end
  // One 125 ns link clock: level before the rise, then level before the fall
  task automatic pulse(input logic d_rise, input logic d_fall);
  begin
    serial_shift_clock = 1'b0;
    #QTR host_data = d_rise;
    #QTR serial_shift_clock = 1'b1;
    #QTR host_data = d_fall;
    #QTR;
  end
  endtask : pulse
  // Free clocks with data high; used while the device sits in reset
  task automatic run_clock(input int n);
  begin
    repeat (n) pulse(1'b1, 1'b1);
  end
  endtask : run_clock
  // Whole frame: start, address MSB first, data first bit first, stop
  task automatic frame(input logic [7:0] addr, input logic [127:0] bits, input logic strobe_low);
    int i;
  begin
    display_latch_strobe = !strobe_low;
    pulse(1'b1, 1'b0);
    for (i = 7; i >= 0; i--) pulse(addr[i], addr[i]);
    for (i = 0; i < 128; i++) pulse(bits[i], bits[i]);
    pulse(1'b0, 1'b1);
  end
  endtask : frame
  // Latch pulse only while the clock idles high; the wait lets it reach the planes
  task automatic strobe_pulse();
  begin
    display_latch_strobe = 1'b1;
    #100 display_latch_strobe = 1'b0;
    #100;
  end
  endtask : strobe_pulse
endmodule : serial_host_model

// *** testbench/lcd_mux4_segment_driver_bench.sv ***
// Self-checking bench for the multiplexed segment driver with a host link model
`timescale 1ns/1ps
module lcd_mux4_segment_driver_bench;
  import lcd_drv_pkg::*;
  // Short phases keep the run brief; the phase-length and wait-bound expectations derive from this value
  localparam int DIV = 8;
  localparam int LIMIT = 60000;
  localparam logic [127:0] PAT_A = 128'h0f0f_a5a5_ffff_0000_1234_5678_8000_0001;
  localparam logic [127:0] PAT_B = 128'h5555_5555_aaaa_aaaa_0000_ffff_7e7e_0101;
  localparam logic [127:0] PAT_C = 128'hc3c3_3c3c_0000_0001_8000_0000_dead_beef;
  logic core_clk;
  logic reset_n;
  logic serial_shift_clock;
  logic host_data;
  logic data_wire;
  logic serial_data_out;
  logic serial_data_oe;
  logic display_latch_strobe;
  logic [2:0] chip_select_straps;
  logic [3:0] common_plane_outputs;
  logic common_plane_boost;
  logic [31:0] segment_plane_outputs;
  int error_cnt = 0;
  int check_count = 0;
  int cycle_cnt = 0;
  // Open-drain data wire: the device only ever pulls low
  assign data_wire = serial_data_oe ? serial_data_out : host_data;
  lcd_mux4_segment_driver #(.SEG_COUNT(128), .PHASE_DIV(DIV), .IIC_VARIANT(1'b0), .FIRST_BITS_PHASE1(1'b1)) dut
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .serial_shift_clock(serial_shift_clock),
    .serial_data_in(data_wire),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .display_latch_strobe(display_latch_strobe),
    .chip_select_straps(chip_select_straps),
    .common_plane_outputs(common_plane_outputs),
    .common_plane_boost(common_plane_boost),
    .segment_plane_outputs(segment_plane_outputs)
  );
  serial_host_model host
  (
    .serial_shift_clock(serial_shift_clock),
    .host_data(host_data),
    .display_latch_strobe(display_latch_strobe),
    .data_wire(data_wire)
  );
  // 250 MHz timebase
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard: a run past the ceiling counts as a mismatch
  always @(posedge core_clk)
  begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == LIMIT)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask : check
  task automatic test_done();
  begin
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask : test_done
  // Bounded wait at falling core edges until the backplane moves
  task automatic wait_change(output int n);
    logic [3:0] prev;
  begin
    prev = common_plane_outputs;
    n = 0;
    while (common_plane_outputs === prev && n < 4 * DIV)
    begin
      @(negedge core_clk);
      n++;
    end
  end
  endtask : wait_change
  // Locks on backplane 1, then checks each phase's block on the frontplanes
  task automatic check_display(input logic [127:0] exp);
    int n;
    int p;
  begin
    n = 0;
    while (common_plane_outputs !== 4'h1 && n < 8 * DIV)
    begin
      wait_change(p);
      n++;
    end
    wait_change(p);
    wait_change(p);
    wait_change(p);
    wait_change(p);
    check(serial_data_oe, 1'b0);
    for (p = 0; p < 4; p++)
    begin
      check(common_plane_outputs, 4'h1 << p);
      check(segment_plane_outputs, exp[p*32 +: 32]);
      wait_change(n);
    end
  end
  endtask : check_display
  // Reset levels, during reset and at the first edge after release
  task automatic test_reset();
  begin
    @(negedge core_clk);
    check({common_plane_outputs, common_plane_boost, segment_plane_outputs, serial_data_oe}, {4'h1, 1'b0, 32'h0, 1'b0});
    @(posedge core_clk) reset_n <= 1'b1;
    @(negedge core_clk);
    check({common_plane_outputs, common_plane_boost, segment_plane_outputs, serial_data_oe}, {4'h1, 1'b0, 32'h0, 1'b0});
  end
  endtask : test_reset
  // Rotation, phase length and the four-cycle high-current window
  task automatic test_sequence();
    logic [3:0] prev;
    int n;
    int k;
  begin
    for (k = 0; k < 5; k++)
    begin
      prev = common_plane_outputs;
      wait_change(n);
      check(common_plane_outputs, {prev[2:0], prev[3]});
      if (k > 0) check(128'(n), 128'(DIV - 5));
      for (n = 0; n < 5; n++)
      begin
        check(common_plane_boost, n < 4);
        @(negedge core_clk);
      end
    end
  end
  endtask : test_sequence
  // Strobe held high: the full block latches by itself
  task automatic test_auto_latch();
  begin
    host.frame(DEV_ADDR, PAT_A, 1'b0);
    check_display(PAT_A);
  end
  endtask : test_auto_latch
  // Wrong address, then wrong straps: the frame is ignored
  task automatic test_refused();
  begin
    host.frame(8'h7c, PAT_B, 1'b0);
    check_display(PAT_A);
    @(posedge core_clk) chip_select_straps <= 3'h3;
    host.frame(DEV_ADDR, PAT_B, 1'b0);
    @(posedge core_clk) chip_select_straps <= STRAP_NORMAL;
    check_display(PAT_A);
  end
  endtask : test_refused
  // Strobe low while sending holds the old image until the pulse
  task automatic test_ext_latch();
  begin
    host.frame(DEV_ADDR, PAT_C, 1'b1);
    check_display(PAT_A);
    host.strobe_pulse();
    check_display(PAT_C);
  end
  endtask : test_ext_latch
  // Main sequence; reset spans several link clocks so the link side settles
  initial
  begin
    reset_n = 1'b0;
    chip_select_straps = STRAP_NORMAL;
    host.run_clock(6);
    test_reset();
    test_sequence();
    // The link side leaves reset only on link edges, so clock it before the first start
    host.run_clock(4);
    test_auto_latch();
    test_refused();
    test_ext_latch();
    test_done();
  end
endmodule : lcd_mux4_segment_driver_bench
